// ### dv/diskette_command_phase_decoder_asserts.sv
`timescale 1ns/1ps
module cmd_phase_checker (
  input wire clk_i, // Clock
  input wire reset_n_i, // Async reset, active low
  input wire wr_stb_i, // Host byte write
  input wire rd_stb_i, // Host takes result
  input wire wr_ready_o, // Byte accepted
  input wire rd_valid_o, // Result present
  input wire [7:0] rd_data_o, // Result byte
  input wire exec_start_o, // Execution start
  input wire exec_write_o, // Write execution
  input wire exec_format_o, // Format execution
  input wire exec_done_i, // Execution finished
  input wire [23:0] exec_status_i, // Status bytes
  input wire step_o, // Step pulse
  input wire int_o // Interrupt pending
);
  reg [7:0] st0_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  always @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
      st0_ff <= 8'h00;
    else
      st0_ff <= exec_status_i[7:0];
  property p_phase_excl; !(wr_ready_o && rd_valid_o); endproperty
  a_phase_excl: assert property (p_phase_excl) else $error("ready during results");
  property p_start_pulse; exec_start_o |=> !exec_start_o; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  property p_start_kind; exec_start_o |-> exec_write_o || exec_format_o; endproperty
  a_start_kind: assert property (p_start_kind) else $error("start without kind");
  property p_exec_quiet; exec_write_o || exec_format_o |-> !wr_ready_o && !rd_valid_o; endproperty
  a_exec_quiet: assert property (p_exec_quiet) else $error("port open in execution");
  property p_exec_hold; exec_write_o && !exec_done_i |=> exec_write_o; endproperty
  a_exec_hold: assert property (p_exec_hold) else $error("write dropped early");
  property p_first_status;
    exec_done_i && (exec_write_o || exec_format_o) |=> rd_valid_o && rd_data_o == st0_ff;
  endproperty
  a_first_status: assert property (p_first_status) else $error("first result wrong");
  property p_rd_hold; rd_valid_o && !rd_stb_i |=> rd_valid_o && $stable(rd_data_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("result not held");
  property p_step_pulse; step_o |=> !step_o; endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step not a pulse");
  property p_int_hold; int_o && !wr_stb_i |=> int_o; endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt lost");
  c_exec: cover property (exec_start_o);
  c_int: cover property ($rose(int_o));
  c_read: cover property (rd_valid_o && rd_stb_i);
endmodule // cmd_phase_checker
bind diskette_command_phase_decoder cmd_phase_checker u_cmd_phase_checker (.clk_i, .reset_n_i,
  .wr_stb_i, .rd_stb_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .exec_start_o, .exec_write_o,
  .exec_format_o, .exec_done_i, .exec_status_i, .step_o, .int_o);

// ### dv/diskette_command_phase_decoder_tb_top.sv
`timescale 1ns/1ps
module diskette_command_phase_decoder_tb_top;
  localparam [23:0] ST = 24'h030241;
  localparam [31:0] ID = 32'h02090146;
  reg clk_i = 1'b0, reset_n_i = 1'b0, wr_stb_i = 1'b0, rd_stb_i = 1'b0, slow_i = 1'b0;
  reg [7:0] wr_data_i = 8'h00;
  reg last_in = 1'b0;
  int n_fail = 0, checked = 0, n_step = 0;
  wire wr_ready_o, rd_valid_o, exec_start_o, exec_write_o, exec_deleted_o, exec_format_o;
  wire multi_track_flag_o, double_density_flag_o, head_side_select_o, no_dma_flag_o;
  wire [7:0] rd_data_o, final_sector_number_o, gap_length_o, data_length_o;
  wire [7:0] sectors_per_track_o, filler_byte_o;
  wire [3:0] step_rate_time_o, head_unload_time_o;
  wire [6:0] head_load_time_o;
  wire [1:0] drive_number_o;
  wire exec_done_i, step_o, step_in_o, step_done_i, int_o;
  wire [23:0] exec_status_i;
  wire [31:0] exec_id_i;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (step_o === 1'b1)
    begin
      n_step <= n_step + 1;
      last_in <= step_in_o;
    end
  diskette_command_phase_decoder u_diskette_command_phase_decoder (.clk_i, .reset_n_i,
    .wr_stb_i, .wr_data_i, .rd_stb_i, .wr_ready_o, .rd_valid_o, .rd_data_o, .exec_start_o,
    .exec_write_o, .exec_deleted_o, .exec_format_o, .multi_track_flag_o,
    .double_density_flag_o, .head_side_select_o, .drive_number_o, .final_sector_number_o,
    .gap_length_o, .data_length_o, .sectors_per_track_o, .filler_byte_o, .step_rate_time_o,
    .head_unload_time_o, .head_load_time_o, .no_dma_flag_o, .exec_done_i, .exec_status_i,
    .exec_id_i, .step_o, .step_in_o, .step_done_i, .int_o);
  drive_side_model #(.ST(ST), .ID(ID)) u_drive_side_model (.clk_i, .reset_n_i, .slow_i,
    .step_i(step_o), .exec_start_i(exec_start_o), .step_done_o(step_done_i),
    .exec_done_o(exec_done_i),
    .status_o(exec_status_i), .id_o(exec_id_i));
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Bounded wait: 0 execution, 1 ready, 2 result, 3 interrupt
  task wt(input int k);
    int i;
    begin
      i = 0;
      while (i < 200 && !(k == 0 ? (exec_write_o | exec_format_o) === 1'b1 :
             k == 1 ? wr_ready_o === 1'b1 : k == 2 ? rd_valid_o === 1'b1 : int_o === 1'b1))
      begin
        @(posedge clk_i);
        #1;
        i++;
      end
      if (i == 200)
      begin
        n_fail++;
        close_out;
      end
    end
  endtask
  task wr(input [7:0] b);
    begin
      wt(1);
      wr_stb_i = 1'b1;
      wr_data_i = b;
      @(posedge clk_i);
      #1;
      wr_stb_i = 1'b0;
      // Idle edge between bytes so the strobe is never raised again in the same step
      @(posedge clk_i);
      #1;
    end
  endtask
  task rd(input [7:0] e, input bit c);
    begin
      wt(2);
      if (c)
        chk(rd_data_o, e);
      rd_stb_i = 1'b1;
      @(posedge clk_i);
      #1;
      rd_stb_i = 1'b0;
      @(posedge clk_i);
      #1;
    end
  endtask
  task t_version;
    begin
      wr(8'h10);
      rd(8'h90, 1);
      chk(rd_valid_o, 1'b0);
    end
  endtask
  task t_write(input [7:0] op, input bit del);
    int k;
    begin
      wr(op);
      wr(8'h05);
      for (k = 0; k < 4; k++)
        wr(8'h20 + k);
      wr(8'h12);
      wr(8'h1B);
      wr(8'hFF);
      wt(0);
      chk({exec_write_o, exec_deleted_o, multi_track_flag_o, double_density_flag_o},
        {1'b1, del, op[7], op[6]});
      chk({head_side_select_o, drive_number_o}, 3'h5);
      chk({final_sector_number_o, gap_length_o, data_length_o}, 24'h121BFF);
      for (k = 0; k < 3; k++)
        rd(ST[8*k+:8], 1);
      for (k = 0; k < 4; k++)
        rd(ID[8*k+:8], 1);
      chk(wr_ready_o, 1'b1);
    end
  endtask
  task t_format;
    int k;
    begin
      wr(8'h4D);
      wr(8'h02);
      wr(8'h02);
      wr(8'h09);
      wr(8'h1B);
      wr(8'hE5);
      wt(0);
      chk({exec_format_o, exec_write_o, drive_number_o}, 4'hA);
      chk({sectors_per_track_o, gap_length_o, filler_byte_o}, 24'h091BE5);
      for (k = 0; k < 3; k++)
        rd(ST[8*k+:8], 1);
      for (k = 0; k < 4; k++)
        rd(8'h00, 0);
      chk(wr_ready_o, 1'b1);
    end
  endtask
  task t_specify;
    begin
      wr(8'h03);
      wr(8'hA5);
      wr(8'h13);
      chk({step_rate_time_o, head_unload_time_o, head_load_time_o, no_dma_flag_o},
        16'hA513);
    end
  endtask
  task t_pos(input [7:0] op, input [7:0] cyl, input bit dir_in);
    begin
      n_step = 0;
      wr(op);
      wr(8'h01);
      if (op == 8'h0F)
        wr(cyl);
      // A second positioning command while the head still moves is refused
      if (op == 8'h07)
      begin
        wr(8'h0F);
        rd(8'h80, 1);
      end
      wt(3);
      chk(n_step, 3);
      chk(last_in, dir_in);
      wr(8'h08);
      rd(8'h21, 1);
      rd(cyl, 1);
      chk(int_o, 1'b0);
    end
  endtask
  task t_invalid;
    begin
      wr(8'h08);
      rd(8'h80, 1);
      wr(8'h00);
      rd(8'h80, 1);
      chk(wr_ready_o, 1'b1);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    t_version;
    t_write(8'hC5, 1'b0);
    t_write(8'h09, 1'b1);
    t_format;
    t_specify;
    t_pos(8'h0F, 8'h03, 1'b1);
    slow_i = 1'b1;
    t_pos(8'h07, 8'h00, 1'b0);
    t_invalid;
    close_out;
  end
endmodule // diskette_command_phase_decoder_tb_top

// ### dv/drive_side_model.sv
`timescale 1ns/1ps
module drive_side_model #(
  parameter [23:0] ST = 24'h000000,
  parameter [31:0] ID = 32'h00000000
) (
  input wire clk_i, // Clock
  input wire reset_n_i, // Async reset, active low
  input wire slow_i, // Slow head steps
  input wire step_i, // Step request
  input wire exec_start_i, // Execution start
  output reg step_done_o, // Step finished
  output reg exec_done_o, // Transfer finished
  output wire [23:0] status_o, // Ending status
  output wire [31:0] id_o // Ending sector ID
);
  reg [3:0] step_cnt_ff;
  reg [3:0] exec_cnt_ff;
  assign status_o = ST;
  assign id_o = ID;
  always @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      step_cnt_ff <= 4'h0;
      exec_cnt_ff <= 4'h0;
      step_done_o <= 1'b0;
      exec_done_o <= 1'b0;
    end
    else
    begin
      step_done_o <= step_cnt_ff == 4'h1;
      exec_done_o <= exec_cnt_ff == 4'h1;
      step_cnt_ff <= step_i ? (slow_i ? 4'h8 : 4'h1) : step_cnt_ff - (step_cnt_ff != 4'h0);
      exec_cnt_ff <= exec_start_i ? 4'h6 : exec_cnt_ff - (exec_cnt_ff != 4'h0);
    end
endmodule // drive_side_model

// ### hdl/cmd_phase_defines.vh
// Summary of operation
// - Write data opcode with multi-track, density flags
// - Write deleted data: same bytes, own opcode
// - Writes return three status, four ID bytes
// - Recalibrate: drive byte, step to zero, interrupt
// - Sense interrupt: status zero then present cylinder
// - Seek: drive byte, target cylinder, no result
// - Undefined opcode returns single status 80H
`ifndef CMD_PHASE_DEFINES_VH
`define CMD_PHASE_DEFINES_VH
`define OPC_VERSION 8'h10
`define OPC_WRITE 5'h05
`define OPC_WRITE_DEL 5'h09
`define OPC_FORMAT 5'h0D
`define OPC_RECAL 8'h07
`define OPC_SENSE_INT 8'h08
`define OPC_SPECIFY 8'h03
`define OPC_SEEK 8'h0F
`define OPC_LOW_MASK 5'h1F
`define FLAG_MT 7
`define FLAG_MFM 6
`define BIT_HDS 2
`define VERSION_RESULT 8'h90
`define INVALID_STATUS 8'h80
`define SENSE_ST0_SEEK_END 8'h20
`define NPAR_WRITE 4'h8
`define NPAR_FORMAT 4'h5
`define NPAR_SPECIFY 4'h2
`define NPAR_RECAL 4'h1
`define NPAR_SEEK 4'h2
`define NRES_WRITE 3'h7
`define NRES_SENSE 3'h2
`define NRES_ONE 3'h1
`define CNT_ONE 4'h1
`define IDX_ONE 3'h1
`define CYL_ZERO 8'h00
`endif

// ### hdl/diskette_command_phase_decoder.v
`timescale 1ns/1ps
`include "cmd_phase_defines.vh"
module diskette_command_phase_decoder (
  input wire clk_i, // Clock, 200 MHz
  input wire reset_n_i, // Async reset, active low
  input wire wr_stb_i, // Host writes a byte
  input wire [7:0] wr_data_i, // Byte written by host
  input wire rd_stb_i, // Host takes the result byte
  output wire wr_ready_o, // Device accepts a command/parameter byte
  output wire rd_valid_o, // Result byte available
  output reg [7:0] rd_data_o, // Result byte
  output reg exec_start_o, // Execution phase start pulse
  output reg exec_write_o, // Execution moves data system to drive
  output reg exec_deleted_o, // Write with deleted-data mark
  output reg exec_format_o, // Execution formats a track
  output reg multi_track_flag_o, // Multi-track flag latched
  output reg double_density_flag_o, // Density flag latched
  output reg head_side_select_o, // Head select latched
  output reg [1:0] drive_number_o, // Drive number latched
  output reg [7:0] final_sector_number_o, // End of track sector
  output reg [7:0] gap_length_o, // Gap length
  output reg [7:0] data_length_o, // Data length
  output reg [7:0] sectors_per_track_o, // Format sectors per track
  output reg [7:0] filler_byte_o, // Format filler
  output reg [3:0] step_rate_time_o, // Specify step rate
  output reg [3:0] head_unload_time_o, // Specify head unload
  output reg [6:0] head_load_time_o, // Specify head load
  output reg no_dma_flag_o, // Specify non-DMA
  input wire exec_done_i, // Drive side finished execution
  input wire [23:0] exec_status_i, // Three status bytes, first in low byte
  input wire [31:0] exec_id_i, // Ending C,H,R,N, C in low byte
  output wire step_o, // Head step pulse
  output wire step_in_o, // Step direction, 1 inward
  input wire step_done_i, // Step completed at drive
  output reg int_o // Interrupt pending after positioning
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_PARAM = 4'b0010;
  localparam ST_EXEC = 4'b0100;
  localparam ST_RESULT = 4'b1000;
  reg [3:0] state_ff;
  reg [7:0] opc_ff;
  reg [3:0] npar_ff;
  reg [3:0] pidx_ff;
  reg [7:0] res_ff [0:7]; // Spare top entry keeps the read past the last result defined
  reg [2:0] nres_ff;
  reg [2:0] ridx_ff;
  reg [7:0] target_ff;
  reg seek_ld_ff;
  reg [7:0] sense_st0_ff;
  reg [1:0] int_drive_ff;
  wire seek_busy;
  wire seek_done;
  wire [1:0] seek_drive;
  wire [31:0] cyl_all;
  wire [4:0] low = wr_data_i[4:0] & `OPC_LOW_MASK;
  wire is_wr = (low == `OPC_WRITE) && !wr_data_i[5];
  wire is_wd = (low == `OPC_WRITE_DEL) && !wr_data_i[5];
  wire is_fmt = (low == `OPC_FORMAT) && !wr_data_i[5] && !wr_data_i[`FLAG_MT];
  wire [4:0] olow = opc_ff[4:0];
  wire take = wr_stb_i && wr_ready_o;
  integer i;
  assign wr_ready_o = (state_ff == ST_IDLE) || (state_ff == ST_PARAM);
  assign rd_valid_o = (state_ff == ST_RESULT);
  drive_cylinder_track u_track (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .load_i(seek_ld_ff),
    .drive_i(drive_number_o),
    .target_i(target_ff),
    .step_done_i(step_done_i),
    .step_o(step_o),
    .step_in_o(step_in_o),
    .busy_o(seek_busy),
    .done_o(seek_done),
    .done_drive_o(seek_drive),
    .cyl_all_o(cyl_all)
  );
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff <= ST_IDLE;
      opc_ff <= 8'h00;
      npar_ff <= 4'h0;
      pidx_ff <= 4'h0;
      nres_ff <= 3'h0;
      ridx_ff <= 3'h0;
      for (i = 0; i < 8; i = i + 1)
        res_ff[i] <= 8'h00;
      rd_data_o <= 8'h00;
      exec_start_o <= 1'b0;
      exec_write_o <= 1'b0;
      exec_deleted_o <= 1'b0;
      exec_format_o <= 1'b0;
      multi_track_flag_o <= 1'b0;
      double_density_flag_o <= 1'b0;
      head_side_select_o <= 1'b0;
      drive_number_o <= 2'h0;
      final_sector_number_o <= 8'h00;
      gap_length_o <= 8'h00;
      data_length_o <= 8'h00;
      sectors_per_track_o <= 8'h00;
      filler_byte_o <= 8'h00;
      step_rate_time_o <= 4'h0;
      head_unload_time_o <= 4'h0;
      head_load_time_o <= 7'h00;
      no_dma_flag_o <= 1'b0;
      target_ff <= `CYL_ZERO;
      seek_ld_ff <= 1'b0;
      sense_st0_ff <= 8'h00;
      int_drive_ff <= 2'h0;
      int_o <= 1'b0;
    end
    else
    begin
      exec_start_o <= 1'b0;
      seek_ld_ff <= 1'b0;
      if (seek_done)
      begin
        int_o <= 1'b1;
        int_drive_ff <= seek_drive;
        sense_st0_ff <= `SENSE_ST0_SEEK_END | {6'h00, seek_drive};
      end
      case (state_ff)
        ST_IDLE:
        begin
          if (take)
          begin
            opc_ff <= wr_data_i;
            pidx_ff <= 4'h0;
            ridx_ff <= 3'h0;
            if (is_wr || is_wd)
            begin
              multi_track_flag_o <= wr_data_i[`FLAG_MT];
              double_density_flag_o <= wr_data_i[`FLAG_MFM];
              exec_deleted_o <= is_wd;
              npar_ff <= `NPAR_WRITE;
              state_ff <= ST_PARAM;
            end
            else if (is_fmt)
            begin
              double_density_flag_o <= wr_data_i[`FLAG_MFM];
              npar_ff <= `NPAR_FORMAT;
              state_ff <= ST_PARAM;
            end
            else if (wr_data_i == `OPC_SPECIFY)
            begin
              npar_ff <= `NPAR_SPECIFY;
              state_ff <= ST_PARAM;
            end
            else if (wr_data_i == `OPC_RECAL && !seek_busy && !seek_ld_ff)
            begin
              npar_ff <= `NPAR_RECAL;
              state_ff <= ST_PARAM;
            end
            else if (wr_data_i == `OPC_SEEK && !seek_busy && !seek_ld_ff)
            begin
              npar_ff <= `NPAR_SEEK;
              state_ff <= ST_PARAM;
            end
            else if (wr_data_i == `OPC_VERSION)
            begin
              res_ff[0] <= `VERSION_RESULT;
              nres_ff <= `NRES_ONE;
              rd_data_o <= `VERSION_RESULT;
              state_ff <= ST_RESULT;
            end
            else if (wr_data_i == `OPC_SENSE_INT && int_o && !seek_done)
            begin
              res_ff[0] <= sense_st0_ff;
              res_ff[1] <= cyl_all[int_drive_ff*8 +: 8];
              rd_data_o <= sense_st0_ff;
              nres_ff <= `NRES_SENSE;
              int_o <= 1'b0;
              state_ff <= ST_RESULT;
            end
            else
            begin
              // Also taken when sense has nothing pending or head is busy
              res_ff[0] <= `INVALID_STATUS;
              rd_data_o <= `INVALID_STATUS;
              nres_ff <= `NRES_ONE;
              state_ff <= ST_RESULT;
            end
          end
        end
        ST_PARAM:
        begin
          if (take)
          begin
            pidx_ff <= pidx_ff + `CNT_ONE;
            if (pidx_ff == 4'h0 && opc_ff != `OPC_SPECIFY)
            begin
              head_side_select_o <= wr_data_i[`BIT_HDS] && opc_ff != `OPC_RECAL;
              drive_number_o <= wr_data_i[1:0];
            end
            if (opc_ff == `OPC_SPECIFY)
            begin
              if (pidx_ff == 4'h0)
              begin
                step_rate_time_o <= wr_data_i[7:4];
                head_unload_time_o <= wr_data_i[3:0];
              end
              else
              begin
                head_load_time_o <= wr_data_i[7:1];
                no_dma_flag_o <= wr_data_i[0];
              end
            end
            else if (olow == `OPC_FORMAT)
            begin
              if (pidx_ff == 4'h2)
                sectors_per_track_o <= wr_data_i;
              if (pidx_ff == 4'h3)
                gap_length_o <= wr_data_i;
              if (pidx_ff == 4'h4)
                filler_byte_o <= wr_data_i;
            end
            else if (opc_ff == `OPC_SEEK)
              target_ff <= wr_data_i;
            else if (opc_ff != `OPC_RECAL)
            begin
              if (pidx_ff == 4'h5)
                final_sector_number_o <= wr_data_i;
              if (pidx_ff == 4'h6)
                gap_length_o <= wr_data_i;
              if (pidx_ff == 4'h7)
                data_length_o <= wr_data_i;
            end
            if (pidx_ff + `CNT_ONE == npar_ff)
            begin
              if (opc_ff == `OPC_SPECIFY)
                state_ff <= ST_IDLE;
              else if (opc_ff == `OPC_RECAL || opc_ff == `OPC_SEEK)
              begin
                if (opc_ff == `OPC_RECAL)
                  target_ff <= `CYL_ZERO;
                seek_ld_ff <= 1'b1;
                state_ff <= ST_IDLE;
              end
              else
              begin
                exec_write_o <= (olow != `OPC_FORMAT);
                exec_format_o <= (olow == `OPC_FORMAT);
                exec_start_o <= 1'b1;
                state_ff <= ST_EXEC;
              end
            end
          end
        end
        ST_EXEC:
        begin
          if (exec_done_i)
          begin
            for (i = 0; i < 3; i = i + 1)
              res_ff[i] <= exec_status_i[i*8 +: 8];
            for (i = 0; i < 4; i = i + 1)
              res_ff[i+3] <= exec_id_i[i*8 +: 8];
            rd_data_o <= exec_status_i[7:0];
            nres_ff <= `NRES_WRITE;
            exec_write_o <= 1'b0;
            exec_format_o <= 1'b0;
            state_ff <= ST_RESULT;
          end
        end
        ST_RESULT:
        begin
          if (rd_stb_i)
          begin
            ridx_ff <= ridx_ff + `IDX_ONE;
            rd_data_o <= res_ff[ridx_ff + `IDX_ONE];
            if (ridx_ff + `IDX_ONE == nres_ff)
              state_ff <= ST_IDLE;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // diskette_command_phase_decoder

// ### hdl/drive_cylinder_track.v
`timescale 1ns/1ps
`include "cmd_phase_defines.vh"
module drive_cylinder_track (
  input wire clk_i, // Clock
  input wire reset_n_i, // Async reset, active low
  input wire load_i, // Start positioning pulse
  input wire [1:0] drive_i, // Drive to move
  input wire [7:0] target_i, // Target cylinder
  input wire step_done_i, // One step finished at drive
  output reg step_o, // Step request pulse
  output reg step_in_o, // Direction: 1 inward
  output reg busy_o, // Positioning in progress
  output reg done_o, // Positioning finished pulse
  output reg [1:0] done_drive_o, // Drive that finished
  output wire [31:0] cyl_all_o // Present cylinder of four drives
);
  reg [7:0] cyl_ff [0:3];
  reg [7:0] target_ff;
  reg [1:0] drv_ff;
  reg wait_ff;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_cyl
      assign cyl_all_o[g*8 +: 8] = cyl_ff[g];
      always @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
          cyl_ff[g] <= `CYL_ZERO;
        else if (busy_o && wait_ff && step_done_i && drv_ff == g)
          cyl_ff[g] <= step_in_o ? cyl_ff[g] + 8'h01 : cyl_ff[g] - 8'h01;
      end
    end
  endgenerate
  wire [7:0] cur = cyl_ff[drv_ff];
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      target_ff <= `CYL_ZERO;
      drv_ff <= 2'h0;
      wait_ff <= 1'b0;
      step_o <= 1'b0;
      step_in_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      done_drive_o <= 2'h0;
    end
    else
    begin
      step_o <= 1'b0;
      done_o <= 1'b0;
      if (load_i && !busy_o)
      begin
        target_ff <= target_i;
        drv_ff <= drive_i;
        busy_o <= 1'b1;
      end
      else if (busy_o)
      begin
        if (wait_ff)
        begin
          if (step_done_i)
            wait_ff <= 1'b0;
        end
        else if (cur == target_ff)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          done_drive_o <= drv_ff;
        end
        else
        begin
          step_in_o <= (target_ff > cur);
          step_o <= 1'b1;
          wait_ff <= 1'b1;
        end
      end
    end
  end
endmodule // drive_cylinder_track
